// [led_source_and_line_tuning_regs.v]
// indicator source and 10M line tuning register slice, wishbone slave
// assumes classic wishbone on sys_clk, status inputs synchronous
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/1ns
`include "led_tuning_regs.vh"
module led_source_and_line_tuning_regs (
  // clock and reset
  input  wire        sys_clk,
  input  wire        sys_rst,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [13:0] wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // link status
  input  wire        linkUp,
  input  wire        txActive,
  input  wire        rxActive,
  input  wire        collision,
  input  wire        speed100,
  input  wire        fullDuplex,
  input  wire        lowPowerIdle,
  input  wire        miiError,
  input  wire        prbsError,
  input  wire        tenMegMode,
  input  wire        mdixActive,
  // clears from the rest of the management space
  input  wire        linkStatusRead,
  input  wire        prbsCountClear,
  // indicators
  output wire        firstIndicator,
  output wire        secondIndicator,
  output wire        thirdIndicator,
  // line settings
  output reg  [3:0]  termCode,
  output reg         termOverride,
  output reg  [4:0]  receiveGainCode,
  output reg         shortGapSelect
);

  // register map, index = byte address / 4, 16-bit registers
  //   0x30e  termination override
  //          15-12 straight pair code, 11 its enable
  //          10-7  crossed pair code, 6 its enable
  //          5-2   spare, stored; 1-0 read as zero
  //   0x404  line driver word, all bits spare, stored
  //   0x40d  receive gain, 4-0 gain code, 15-5 spare
  //   0x456  general config, 3 short gap select
  //   0x460  indicator sources: 15-12 first,
  //          11-8 second, 7-4 third, 3-0 spare
  // every register answers reads in full; spare bits
  // are kept only so software sees what it wrote, and
  // nothing in the slice looks at them
  // an index outside this list is refused with err
  // and never changes a register
  // stored registers
  reg  [15:0] termOverrideReg;          // ten_meg_termination_override
  reg  [15:0] ldProgReserved;           // line_driver_program_reserved
  reg  [15:0] rxGainReg;                // ten_base_receive_gain
  reg  [15:0] genConfig;                // general_config
  reg  [15:0] indSourceConfig;          // indicator_source_config

  // bus timing, all on the rising edge of sys_clk:
  //   edge n   cyc and stb seen with no answer pending;
  //            a write lands in its register here
  //   edge n+1 ack (or err) stands for one cycle, read
  //            data stands beside it, zero otherwise
  //   edge n+2 ack drops whether or not the master
  //            has released cyc and stb yet
  // the pending-answer term in the request stops a
  // master that is slow to release from being served
  // twice; the price is one idle cycle between
  // back-to-back requests
  // only byte lanes 1-0 matter, the upper lanes of a
  // 32-bit bus have no storage behind them
  // decoded request
  wire [11:0] regIndex = wb_adr_i[13:2];
  wire        request  = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire        doWrite  = request & wb_we_i;
  wire [15:0] laneMask = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  reg         hit;
  reg  [15:0] readWord;

  // both pairings share one set of outputs: termCode
  // carries whichever code belongs to the pairing
  // that is active now
  // fields
  wire [3:0] straightCode   = termOverrideReg[`STRAIGHT_CODE_HI:
                                              `STRAIGHT_CODE_LO];
  wire       straightEnable = termOverrideReg[`STRAIGHT_EN_BIT];
  wire [3:0] crossedCode    = termOverrideReg[`CROSSED_CODE_HI:
                                              `CROSSED_CODE_LO];
  wire       crossedEnable  = termOverrideReg[`CROSSED_EN_BIT];

  // merges write data into a register under the byte lanes
  function [15:0] merge;
    input [15:0] old;
    input [15:0] data;
    input [15:0] mask;
    begin
      merge = (old & ~mask) | (data & mask);
    end
  endfunction

  // a plain if chain, so a new register slots in
  // without touching the others; hit feeds both the
  // answer type and the write enable, so a refused
  // index can never store anything
  // address decode and read mux; an unmapped index answers with err
  always @* begin
    hit      = 1'b1;
    readWord = 16'h0000;
    if (regIndex == `TERM_OVERRIDE_IDX)
      readWord = termOverrideReg;
    else if (regIndex == `LD_PROG_RSVD_IDX)
      readWord = ldProgReserved;
    else if (regIndex == `RX_GAIN_IDX)
      readWord = rxGainReg;
    else if (regIndex == `GEN_CONFIG_IDX)
      readWord = genConfig;
    else if (regIndex == `IND_SOURCE_IDX)
      readWord = indSourceConfig;
    else
      hit = 1'b0;
  end

  // writes merge under the byte lanes, so software
  // may update one byte without a read first
  // the termination register keeps its two lowest
  // bits at zero whatever is written
  // the last branch needs no compare: hit is set
  // and every other index has been ruled out
  // register writes; reserved bits are stored but steer nothing
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      termOverrideReg <= `TERM_OVERRIDE_RST;
      ldProgReserved  <= `LD_PROG_RSVD_RST;
      rxGainReg       <= `RX_GAIN_RST;
      genConfig       <= `GEN_CONFIG_RST;
      indSourceConfig <= `IND_SOURCE_RST;
    end else if (doWrite && hit) begin
      if (regIndex == `TERM_OVERRIDE_IDX)
        termOverrideReg <= merge(termOverrideReg, wb_dat_i[15:0],
                                 laneMask & `TERM_OVERRIDE_MASK);
      else if (regIndex == `LD_PROG_RSVD_IDX)
        ldProgReserved <= merge(ldProgReserved, wb_dat_i[15:0],
                                laneMask);
      else if (regIndex == `RX_GAIN_IDX)
        rxGainReg <= merge(rxGainReg, wb_dat_i[15:0], laneMask);
      else if (regIndex == `GEN_CONFIG_IDX)
        genConfig <= merge(genConfig, wb_dat_i[15:0], laneMask);
      else
        indSourceConfig <= merge(indSourceConfig, wb_dat_i[15:0],
                                 laneMask);
    end
  end

  // read data is cleared outside a read answer so a
  // shared bus may or the slaves' data together
  // err and ack are never high together
  // single cycle answer, dropped the cycle after it is given
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= request & hit;
      wb_err_o <= request & ~hit;
      if (request && hit && !wb_we_i)
        wb_dat_o <= {16'h0000, readWord};
      else
        wb_dat_o <= 32'h00000000;
    end
  end

  // line settings are registered once more so the
  // analog side sees clean levels from flip-flops
  // termination: code 0 asks for the highest value
  // and each step lowers it, down to code fh; the
  // code is honoured only in 10M mode and with the
  // enable of the active pairing set
  // with the enable clear the analog side keeps its
  // own default, so termOverride tells it which
  // of the two to use
  // receive gain: code 0 is the smallest setting,
  // each step adds 25mV to the 200mV floor; it is
  // passed on in every mode, the analog side only
  // uses it in 10BASE-T
  // short gap: one selects the 120ns minimum
  // inter-packet gap, zero the 200ns one
  // a pairing change takes effect one edge later,
  // the same as a register write
  // line settings: override only in 10M mode on the active pairing
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      termCode        <= 4'h0;
      termOverride    <= 1'b0;
      receiveGainCode <= 5'h00;
      shortGapSelect  <= 1'b1;
    end else begin
      if (mdixActive) begin
        termCode     <= crossedCode;
        termOverride <= tenMegMode & crossedEnable;
      end else begin
        termCode     <= straightCode;
        termOverride <= tenMegMode & straightEnable;
      end
      receiveGainCode <= rxGainReg[`RX_GAIN_HI:`RX_GAIN_LO];
      shortGapSelect  <= genConfig[`SHORT_GAP_BIT];
    end
  end

  // the stretch and the blink share one counter
  // length of 50 ms; the blink counter runs free
  // and only matters while activity is stretched,
  // so the lamp may start a blink at any phase
  // one shaper serves all three lamps, so two lamps
  // on the blinking code blink in step
  // 20-bit counters cover 1,000,000 cycles with
  // room to spare; a faster clock needs wider ones
  // activity shaping shared by all three indicators
  wire stretched;
  wire blinkPhase;
  activity_shaper #(
    .HOLD_CYCLES (`BLINK_MS * `CLK_KHZ)
  ) shaper (
    .sys_clk    (sys_clk),
    .sys_rst    (sys_rst),
    .activity   (txActive | rxActive),
    .stretched  (stretched),
    .blinkPhase (blinkPhase)
  );

  // source codes of each selector:
  //   0 link up          1 tx or rx activity
  //   2 tx activity      3 rx activity
  //   4 collision        5 link at 100 Mb/s
  //   6 link at 10 Mb/s  7 full duplex
  //   8 link, blinking while traffic is stretched
  //   9 stretched activity
  //   a link at 100 Mb/s full duplex
  //   b low-power idle
  //   c error on the MAC side of the MII
  //   d link lost, held until the status read
  //   e test pattern error, held until cleared
  //   f reserved, lamp dark
  // the latched codes keep their flags in every
  // selector, so switching a lamp to d or e shows
  // an event that came while it showed another code
  // one selector per indicator
  wire [11:0] sources = indSourceConfig[`FIRST_SRC_HI:`THIRD_SRC_LO];
  wire [2:0]  lamps;
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : lamp
      indicator_select sel (
        .sys_clk        (sys_clk),
        .sys_rst        (sys_rst),
        .source         (sources[4*i+3:4*i]),
        .linkUp         (linkUp),
        .txActive       (txActive),
        .rxActive       (rxActive),
        .collision      (collision),
        .speed100       (speed100),
        .fullDuplex     (fullDuplex),
        .lowPowerIdle   (lowPowerIdle),
        .miiError       (miiError),
        .prbsError      (prbsError),
        .stretched      (stretched),
        .blinkPhase     (blinkPhase),
        .linkStatusRead (linkStatusRead),
        .prbsCountClear (prbsCountClear),
        .indicator      (lamps[i])
      );
    end
  endgenerate

  // lamps[2] is the first selector (bits 15-12)
  // the generate index counts up from the low field,
  // so the first lamp takes the highest index
  assign firstIndicator  = lamps[2];
  assign secondIndicator = lamps[1];
  assign thirdIndicator  = lamps[0];

endmodule // led_source_and_line_tuning_regs

// [led_tuning_regs.vh]
// register offsets, field positions and reset values of the
// indicator source and line tuning register slice
// assumes a wishbone byte address equal to four times the register index
`ifndef LED_TUNING_REGS_VH
`define LED_TUNING_REGS_VH

// register indices, byte address is four times the index
`define TERM_OVERRIDE_IDX    12'h30e
`define LD_PROG_RSVD_IDX     12'h404
`define RX_GAIN_IDX          12'h40d
`define GEN_CONFIG_IDX       12'h456
`define IND_SOURCE_IDX       12'h460
// index of the management status register whose read clears link loss
`define LINK_STATUS_IDX      12'h001

// reset values
`define TERM_OVERRIDE_RST    16'h0000
`define LD_PROG_RSVD_RST     16'h0080
`define RX_GAIN_RST          16'h0000
`define GEN_CONFIG_RST       16'h0008
`define IND_SOURCE_RST       16'h5665

// field positions
`define STRAIGHT_CODE_HI     15
`define STRAIGHT_CODE_LO     12
`define STRAIGHT_EN_BIT      11
`define CROSSED_CODE_HI      10
`define CROSSED_CODE_LO      7
`define CROSSED_EN_BIT       6
`define RX_GAIN_HI           4
`define RX_GAIN_LO           0
`define SHORT_GAP_BIT        3
`define FIRST_SRC_HI         15
`define FIRST_SRC_LO         12
`define SECOND_SRC_HI        11
`define SECOND_SRC_LO        8
`define THIRD_SRC_HI         7
`define THIRD_SRC_LO         4
// writable mask of the termination register, bits 1-0 read as zero
`define TERM_OVERRIDE_MASK   16'hfffc

// indicator source codes
`define SRC_LINK             4'h0
`define SRC_ACT              4'h1
`define SRC_TX_ACT           4'h2
`define SRC_RX_ACT           4'h3
`define SRC_COLLISION        4'h4
`define SRC_SPEED100         4'h5
`define SRC_SPEED10          4'h6
`define SRC_FULL_DUPLEX      4'h7
`define SRC_LINK_BLINK       4'h8
`define SRC_STRETCH          4'h9
`define SRC_LINK_100FD       4'ha
`define SRC_LOW_POWER_IDLE   4'hb
`define SRC_MII_ERROR        4'hc
`define SRC_LINK_LOST        4'hd
`define SRC_PRBS_ERROR       4'he

// timing: blink half period and activity stretch, in ms at 20 MHz
`define BLINK_MS             50
`define STRETCH_MS           50
`define CLK_KHZ              20000

`endif

// [activity_shaper.v]
// activity stretcher and blinker shared by the indicator selectors
// assumes sys_clk at 20 MHz and activity as a level sampled each clock
`timescale 1ns/1ns
module activity_shaper #(
  parameter HOLD_CYCLES = 1000000       // stretch length and blink half period
) (
  // clock and reset
  input  wire sys_clk,
  input  wire sys_rst,
  // activity in
  input  wire activity,
  // shaped outputs
  output reg  stretched,
  output reg  blinkPhase
);

  reg [19:0] holdCount;                 // stretch countdown
  reg [19:0] blinkCount;                // blink half period counter

  // retrigger the stretch on every activity cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      holdCount <= 20'h00000;
      stretched <= 1'b0;
    end else if (activity) begin
      holdCount <= HOLD_CYCLES[19:0];
      stretched <= 1'b1;
    end else if (holdCount != 20'h00000) begin
      holdCount <= holdCount - 20'h00001;
      stretched <= (holdCount != 20'h00001);
    end else begin
      stretched <= 1'b0;
    end
  end

  // free-running toggle; only looked at while activity is stretched
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      blinkCount <= 20'h00000;
      blinkPhase <= 1'b0;
    end else if (blinkCount >= HOLD_CYCLES[19:0] - 20'h00001) begin
      blinkCount <= 20'h00000;
      blinkPhase <= ~blinkPhase;
    end else begin
      blinkCount <= blinkCount + 20'h00001;
    end
  end

endmodule // activity_shaper

// [indicator_select.v]
// one indicator source multiplexer with its latched event flags
// assumes status inputs are synchronous levels and clears are pulses
`timescale 1ns/1ns
`include "led_tuning_regs.vh"
module indicator_select (
  // clock and reset
  input  wire       sys_clk,
  input  wire       sys_rst,
  // selector
  input  wire [3:0] source,
  // status
  input  wire       linkUp,
  input  wire       txActive,
  input  wire       rxActive,
  input  wire       collision,
  input  wire       speed100,
  input  wire       fullDuplex,
  input  wire       lowPowerIdle,
  input  wire       miiError,
  input  wire       prbsError,
  input  wire       stretched,
  input  wire       blinkPhase,
  // latch clears
  input  wire       linkStatusRead,
  input  wire       prbsCountClear,
  // indicator
  output reg        indicator
);

  reg  linkLost;                        // latched link-loss event
  reg  prbsSeen;                        // latched test pattern error
  reg  linkPrev;                        // link level one cycle ago
  wire linkDrop = linkPrev & ~linkUp;   // falling edge of link
  reg  next_indicator;

  // latches: a new event wins over a clear in the same cycle
  always @(posedge sys_clk) begin
    if (sys_rst) begin
      linkPrev <= 1'b0;
      linkLost <= 1'b0;
      prbsSeen <= 1'b0;
    end else begin
      linkPrev <= linkUp;
      if (linkDrop)
        linkLost <= 1'b1;
      else if (linkStatusRead)
        linkLost <= 1'b0;
      if (prbsError)
        prbsSeen <= 1'b1;
      else if (prbsCountClear)
        prbsSeen <= 1'b0;
    end
  end

  // source decode; the reserved code shows dark
  always @* begin
    case (source)
      `SRC_LINK:           next_indicator = linkUp;
      `SRC_ACT:            next_indicator = txActive | rxActive;
      `SRC_TX_ACT:         next_indicator = txActive;
      `SRC_RX_ACT:         next_indicator = rxActive;
      `SRC_COLLISION:      next_indicator = collision;
      `SRC_SPEED100:       next_indicator = linkUp & speed100;
      `SRC_SPEED10:        next_indicator = linkUp & ~speed100;
      `SRC_FULL_DUPLEX:    next_indicator = fullDuplex;
      `SRC_LINK_BLINK:
        next_indicator = linkUp & ~(stretched & blinkPhase);
      `SRC_STRETCH:        next_indicator = stretched;
      `SRC_LINK_100FD:
        next_indicator = linkUp & speed100 & fullDuplex;
      `SRC_LOW_POWER_IDLE: next_indicator = lowPowerIdle;
      `SRC_MII_ERROR:      next_indicator = miiError;
      `SRC_LINK_LOST:      next_indicator = linkLost;
      `SRC_PRBS_ERROR:     next_indicator = prbsSeen;
      default:             next_indicator = 1'b0;
    endcase
  end

  // registered so the pin comes straight from a flip-flop
  always @(posedge sys_clk) begin
    if (sys_rst)
      indicator <= 1'b0;
    else
      indicator <= next_indicator;
  end

endmodule // indicator_select

// [indicator_leds.sv]
// model of the three indicator lamps on the far side of the slice
// assumes active-high drive straight from the indicator outputs
`timescale 1ns/1ns
module indicator_leds (
  // drive from the slice
  input  wire  [2:0] drive,
  // lamp state seen by the bench
  output logic [2:0] lit
);
  // a lamp has no memory: lit exactly while driven
  assign lit = drive;
endmodule // indicator_leds

// [led_regs_chk.sv]
// bus and line output checks of the indicator and line tuning slice
// sees only the top module's ports; bound at the foot of this file
`timescale 1ns/1ns
`include "led_tuning_regs.vh"
module led_regs_chk (
  // clock and reset
  input wire        sys_clk,
  input wire        sys_rst,
  // wishbone
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire [13:0] wb_adr_i,
  input wire [3:0]  wb_sel_i,
  input wire [31:0] wb_dat_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire        wb_err_o,
  // line settings
  input wire        tenMegMode,
  input wire [3:0]  termCode,
  input wire        termOverride,
  input wire [4:0]  receiveGainCode,
  input wire        shortGapSelect
);
  // register index of the request
  wire [11:0] idx = wb_adr_i[13:2];
  // index belongs to the slice
  wire mapped = idx == `TERM_OVERRIDE_IDX || idx == `LD_PROG_RSVD_IDX ||
                idx == `RX_GAIN_IDX || idx == `GEN_CONFIG_IDX ||
                idx == `IND_SOURCE_IDX;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  // request taken at this edge
  sequence req_taken;
    wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  endsequence
  // low byte write taken at a given index
  sequence wr_at(logic [11:0] i);
    req_taken ##0 (wb_we_i && wb_sel_i[0] && idx == i);
  endsequence

  a_ack_mapped: assert property (req_taken ##0 mapped |=>
    wb_ack_o && !wb_err_o)
    else $error("mapped request not acknowledged");
  a_err_unmapped: assert property (req_taken ##0 !mapped |=>
    wb_err_o && !wb_ack_o && wb_dat_o == 32'h0)
    else $error("unmapped request not refused");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_no_stray: assert property ((wb_ack_o || wb_err_o) |->
    $past(wb_cyc_i && wb_stb_i))
    else $error("answer without request");
  a_data_quiet: assert property ((!wb_ack_o || wb_we_i) |->
    wb_dat_o == 32'h0)
    else $error("read data outside a read answer");
  a_upper_zero: assert property (wb_dat_o[31:16] == 16'h0)
    else $error("upper read data not zero");
  a_gain_follow: assert property (wr_at(`RX_GAIN_IDX) |=> ##1
    receiveGainCode == $past(wb_dat_i[4:0], 2))
    else $error("gain output does not follow write");
  a_gap_follow: assert property (wr_at(`GEN_CONFIG_IDX) |=> ##1
    shortGapSelect == $past(wb_dat_i[3], 2))
    else $error("gap output does not follow write");
  a_term_mode: assert property (termOverride |-> $past(tenMegMode))
    else $error("override outside ten meg mode");
  a_reset_vals: assert property ($fell(sys_rst) |->
    shortGapSelect && !termOverride && termCode == 4'h0 &&
    receiveGainCode == 5'h0)
    else $error("line outputs wrong after reset");
endmodule // led_regs_chk

bind led_source_and_line_tuning_regs led_regs_chk u_chk (
  .sys_clk(sys_clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o), .tenMegMode(tenMegMode),
  .termCode(termCode), .termOverride(termOverride),
  .receiveGainCode(receiveGainCode), .shortGapSelect(shortGapSelect));

// [tb_top.sv]
// self-checking bench of the indicator and line tuning slice
// assumes answers within the bench timeout and 50 ms activity stretch
`timescale 1ns/1ns
`include "led_tuning_regs.vh"
module tb_top;
  logic        sysClk = 1'b0;   // 20 MHz
  logic        sysRst = 1'b1;   // synchronous reset
  logic        cyc = 1'b0;      // wishbone master
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic [13:0] adr = 14'h0;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0;
  wire  [31:0] rdat;
  wire         ack;
  wire         err;
  logic [9:0]  st = 10'h0;      // link tx rx col s100 fd lpi mii ten mdix
  logic [2:0]  pl = 3'h0;       // pulses: prbs error, prbs clear, read
  wire  [2:0]  ind;
  wire  [2:0]  lit;
  wire  [3:0]  termCode;
  wire         termOverride;
  wire  [4:0]  gain;
  wire         gap;
  int          n_mismatch = 0;
  int          check_count = 0;
  int          cycles = 0;
  logic [15:0] q;               // last read data
  logic        e;               // last error answer
  logic [3:0]  codes [12] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 10, 11, 12};
  logic [9:0]  pats [2] = '{10'h338, 10'h2c4};

  led_source_and_line_tuning_regs dut (
    .sys_clk(sysClk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wb_err_o(err),
    .linkUp(st[9]), .txActive(st[8]), .rxActive(st[7]), .collision(st[6]),
    .speed100(st[5]), .fullDuplex(st[4]), .lowPowerIdle(st[3]),
    .miiError(st[2]), .prbsError(pl[2]), .tenMegMode(st[1]),
    .mdixActive(st[0]), .linkStatusRead(pl[0]), .prbsCountClear(pl[1]),
    .firstIndicator(ind[2]), .secondIndicator(ind[1]),
    .thirdIndicator(ind[0]), .termCode(termCode),
    .termOverride(termOverride), .receiveGainCode(gain),
    .shortGapSelect(gap));
  indicator_leds leds (.drive(ind), .lit(lit));

  // clock
  always #25 sysClk = ~sysClk;

  // hang guard, the run needs well under a thousand cycles
  always @(posedge sysClk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      results();
    end
  end

  // expected indicator for a code and a steady status; the blink
  // starts in its lit half, which outlasts the whole run
  function automatic logic expInd(input logic [3:0] c, input logic [9:0] s);
    case (c)
      4'h0: return s[9];
      4'h1, 4'h9: return s[8] | s[7];
      4'h2: return s[8];
      4'h3: return s[7];
      4'h4: return s[6];
      4'h5: return s[9] & s[5];
      4'h6: return s[9] & ~s[5];
      4'h7: return s[4];
      4'h8: return s[9];
      4'ha: return s[9] & s[5] & s[4];
      4'hb: return s[3];
      4'hc: return s[2];
      default: return 1'b0;
    endcase
  endfunction

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [15:0] x,
                     input logic [15:0] g);
    check_count++;
    if (g !== x) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", n, x, g);
    end
  endtask

  // one classic cycle, held until the answer edge
  task automatic wb(input logic w, input logic [11:0] i, input logic [15:0] d);
    @(posedge sysClk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= {i, 2'b00};
    wdat <= {16'h0, d};
    sel <= 4'h3;
    do @(posedge sysClk); while (ack !== 1'b1 && err !== 1'b1);
    q = rdat[15:0];
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] i, input logic [15:0] d);
    wb(1'b1, i, d);
  endtask

  task automatic rd(input logic [11:0] i, input logic [15:0] x);
    wb(1'b0, i, 16'h0);
    chk("read data", x, q);
  endtask

  task automatic settle();
    repeat (4) @(posedge sysClk);
  endtask

  // one-cycle pulse on a latch input
  task automatic pulse(input int b);
    @(posedge sysClk);
    pl[b] <= 1'b1;
    @(posedge sysClk);
    pl[b] <= 1'b0;
    settle();
  endtask

  // same code on all three outputs under a given status
  task automatic ledchk(input logic [3:0] c, input logic [9:0] s);
    wr(`IND_SOURCE_IDX, {c, c, c, 4'h5});
    st <= s;
    settle();
    chk("indicators", {3{expInd(c, s)}}, lit);
  endtask

  initial begin
    repeat (4) @(posedge sysClk);
    sysRst <= 1'b0;
    rd(`TERM_OVERRIDE_IDX, `TERM_OVERRIDE_RST);
    rd(`LD_PROG_RSVD_IDX, `LD_PROG_RSVD_RST);
    rd(`RX_GAIN_IDX, `RX_GAIN_RST);
    rd(`GEN_CONFIG_IDX, `GEN_CONFIG_RST);
    rd(`IND_SOURCE_IDX, `IND_SOURCE_RST);
    chk("gap select", 16'h1, gap);
    wb(1'b0, 12'h123, 16'h0);
    chk("unmapped err", 16'h1, e);
    wr(`TERM_OVERRIDE_IDX, 16'hffff);
    rd(`TERM_OVERRIDE_IDX, 16'hfffc);
    wr(`LD_PROG_RSVD_IDX, 16'ha5a5);
    rd(`LD_PROG_RSVD_IDX, 16'ha5a5);
    wr(`RX_GAIN_IDX, 16'hfff3);
    rd(`RX_GAIN_IDX, 16'hfff3);
    chk("gain code", 16'h13, gain);
    wr(`GEN_CONFIG_IDX, 16'hfff7);
    rd(`GEN_CONFIG_IDX, 16'hfff7);
    chk("gap select", 16'h0, gap);
    // termination override, straight pair then crossed pair
    st <= 10'h002;
    wr(`TERM_OVERRIDE_IDX, 16'hbb00);
    settle();
    chk("termination", 16'h1b, {termOverride, termCode});
    st <= 10'h003;
    settle();
    chk("termination", 16'h06, {termOverride, termCode});
    wr(`TERM_OVERRIDE_IDX, 16'h03c0);
    settle();
    chk("termination", 16'h17, {termOverride, termCode});
    st <= 10'h001;
    settle();
    chk("override", 16'h0, termOverride);
    // steady link before any activity, so no stretch is running
    ledchk(4'h8, 10'h200);
    ledchk(4'h8, 10'h000);
    foreach (pats[p])
      foreach (codes[k])
        ledchk(codes[k], pats[p]);
    ledchk(4'h9, pats[0]);
    ledchk(4'hf, pats[0]);
    // distinct sources on the three outputs
    wr(`IND_SOURCE_IDX, 16'h2355);
    st <= pats[1];
    settle();
    chk("mixed sources", 16'h2, lit);
    // link loss: the drop in the code 8 test is still held
    wr(`IND_SOURCE_IDX, 16'hddd5);
    st <= 10'h200;
    settle();
    chk("link lost", 16'h7, lit);
    pulse(0);
    chk("link lost", 16'h0, lit);
    st <= 10'h000;
    settle();
    st <= 10'h200;
    settle();
    chk("link lost", 16'h7, lit);
    pulse(0);
    chk("link lost", 16'h0, lit);
    // prbs error latched until the counter clear
    wr(`IND_SOURCE_IDX, 16'heee5);
    pulse(1);
    chk("prbs error", 16'h0, lit);
    pulse(2);
    chk("prbs error", 16'h7, lit);
    pulse(1);
    chk("prbs error", 16'h0, lit);
    results();
  end
endmodule // tb_top
